/* File: core/mmu_ctrl_defines.svh */
`ifndef MMU_CTRL_DEFINES_SVH
`define MMU_CTRL_DEFINES_SVH
`define NUM_LEVELS      16
`define PCR_PT_HI       10
`define PCR_PT_LO       9
`define PCR_APT_HI      8
`define PCR_APT_LO      7
`define PCR_LVL_HI      6
`define PCR_LVL_LO      3
`define PCR_RING_HI     1
`define PCR_RING_LO     0
`define FS_FETCH_BIT    15
`define FS_PERMIT_BIT   14
`define FS_PT_HI        7
`define FS_PT_LO        6
`define FS_VPN_HI       5
`define FS_VPN_LO       0
`define RING_PRIV_MIN   2'h2
`define MMU_IRQ_LEVEL   4'hE
`define IIC_PROTECT     4'h2
`define IIC_PAGE_FAULT  4'h3
`define IIC_PRIV_INSTR  4'h4
`define IIC_SUPER_CALL  4'h1
`define PADDR_NORMAL    5'h13
`define PADDR_WIDE      5'h18
`define STS_WIDE_BIT    13
`endif

/* File: core/mmu_ctrl_pkg.sv */
package mmu_ctrl_pkg;
   typedef enum logic [3:0] {
      OP_PLAIN      = 4'h0,
      OP_IO         = 4'h1,
      OP_MM_INT     = 4'h2,
      OP_INTERLEVEL = 4'h3,
      OP_SUPER_CALL = 4'h4,
      OP_PAGING_ON  = 4'h5,
      OP_PAGING_OFF = 4'h6,
      OP_SET_WIDE   = 4'h7,
      OP_RESET_WIDE = 4'h8,
      OP_WR_PCR     = 4'h9,
      OP_RD_PCR     = 4'hA,
      OP_RD_FAULT   = 4'hB
   } instr_op_t;
   typedef struct packed {
      logic       is_fetch;
      logic       permit;
      logic       ring;
      logic       page_miss;
      logic [1:0] page_table_select;
      logic [5:0] virtual_page_index;
   } fault_info_t;
   typedef struct packed {
      logic [1:0] page_table_select;
      logic [1:0] alt_page_table_select;
      logic [1:0] ring;
   } pcr_entry_t;
endpackage : mmu_ctrl_pkg

/* File: core/paging_ctrl_store.sv */
`timescale 1ns/1ps
`default_nettype none
module paging_ctrl_store #(
   parameter int LEVELS = 16
) (
   input  wire logic                       clk,
   input  wire logic                       rst_b,
   input  wire logic                       wr_en,
   input  wire logic [$clog2(LEVELS)-1:0]  wr_level,
   input  wire mmu_ctrl_pkg::pcr_entry_t   wr_entry,
   input  wire logic [$clog2(LEVELS)-1:0]  rd_level_a,
   input  wire logic [$clog2(LEVELS)-1:0]  rd_level_b,
   output mmu_ctrl_pkg::pcr_entry_t        rd_entry_a,
   output mmu_ctrl_pkg::pcr_entry_t        rd_entry_b
);
   mmu_ctrl_pkg::pcr_entry_t entry_q [LEVELS];

   // one register per program level, only the addressed one loads
   for (genvar i = 0; i < LEVELS; i++) begin : g_level
      always_ff @(posedge clk) begin
         if (!rst_b) begin
            entry_q[i] <= '0;
         end else if (wr_en && (wr_level == i)) begin
            entry_q[i] <= wr_entry;
         end
      end
   end

   // read ports: read-back level and running level
   assign rd_entry_a = entry_q[rd_level_a];
   assign rd_entry_b = entry_q[rd_level_b];
endmodule : paging_ctrl_store
`default_nettype wire

/* File: core/paging_control_and_privilege.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mmu_ctrl_defines.svh"
module paging_control_and_privilege #(
   parameter int LEVELS = `NUM_LEVELS
) (
   input  wire logic                        MCLK,
   input  wire logic                        RST_B,
   input  wire logic                        INSTR_VALID,
   input  wire mmu_ctrl_pkg::instr_op_t     INSTR_OP,
   input  wire logic [7:0]                  INSTR_PARAM,
   input  wire logic [15:0]                 ACC_IN,
   input  wire logic [1:0]                  EXEC_RING,
   input  wire logic [3:0]                  CUR_LEVEL,
   input  wire logic                        FAULT_VALID,
   input  wire mmu_ctrl_pkg::fault_info_t   FAULT_INFO,
   output logic                             EXEC_DONE,
   output logic                             EXEC_SUPPRESS,
   output logic                             IRQ_VALID,
   output logic [3:0]                       IRQ_LEVEL,
   output logic [3:0]                       IRQ_CODE,
   output logic [7:0]                       SVC_NUM,
   output logic                             ACC_VALID,
   output logic [15:0]                      ACC_OUT,
   output logic                             MAP_ON,
   output logic                             PROTECT_ON,
   output logic                             STS_WIDE,
   output logic [4:0]                       PHYS_ADDR_BITS,
   output logic                             PC_HOLD,
   output mmu_ctrl_pkg::pcr_entry_t         CUR_PCR
);
   // ************************************************************
   // instruction decode
   // ************************************************************
   logic                      map_q;
   logic                      wide_q;
   logic [15:0]               fs_q;
   logic                      fs_locked_q;
   mmu_ctrl_pkg::pcr_entry_t  rd_entry;
   mmu_ctrl_pkg::pcr_entry_t  cur_entry;
   mmu_ctrl_pkg::pcr_entry_t  wr_entry;

   // privileged groups and paging/address mode instructions
   wire op_priv = INSTR_OP inside {mmu_ctrl_pkg::OP_IO, mmu_ctrl_pkg::OP_MM_INT,
                                   mmu_ctrl_pkg::OP_INTERLEVEL,
                                   mmu_ctrl_pkg::OP_PAGING_ON,
                                   mmu_ctrl_pkg::OP_PAGING_OFF,
                                   mmu_ctrl_pkg::OP_SET_WIDE,
                                   mmu_ctrl_pkg::OP_RESET_WIDE,
                                   mmu_ctrl_pkg::OP_WR_PCR,
                                   mmu_ctrl_pkg::OP_RD_PCR,
                                   mmu_ctrl_pkg::OP_RD_FAULT};
   // unmapped mode lifts the ring check
   wire ring_ok    = !map_q || (EXEC_RING >= `RING_PRIV_MIN);
   wire instr_go   = INSTR_VALID && (!op_priv || ring_ok);
   wire instr_trap = INSTR_VALID && op_priv && !ring_ok;
   wire go_pon     = instr_go && (INSTR_OP == mmu_ctrl_pkg::OP_PAGING_ON);
   wire go_pof     = instr_go && (INSTR_OP == mmu_ctrl_pkg::OP_PAGING_OFF);
   wire go_sex     = instr_go && (INSTR_OP == mmu_ctrl_pkg::OP_SET_WIDE);
   wire go_rex     = instr_go && (INSTR_OP == mmu_ctrl_pkg::OP_RESET_WIDE);
   wire go_wpcr    = instr_go && (INSTR_OP == mmu_ctrl_pkg::OP_WR_PCR);
   wire go_rpcr    = instr_go && (INSTR_OP == mmu_ctrl_pkg::OP_RD_PCR);
   wire go_rfs     = instr_go && (INSTR_OP == mmu_ctrl_pkg::OP_RD_FAULT);
   wire go_svc     = instr_go && (INSTR_OP == mmu_ctrl_pkg::OP_SUPER_CALL);

   // ************************************************************
   // paging control registers
   // ************************************************************
   // only table, alternative table and ring are kept
   assign wr_entry.page_table_select     = ACC_IN[`PCR_PT_HI:`PCR_PT_LO];
   assign wr_entry.alt_page_table_select = ACC_IN[`PCR_APT_HI:`PCR_APT_LO];
   assign wr_entry.ring                  = ACC_IN[`PCR_RING_HI:`PCR_RING_LO];
   wire [3:0] acc_level = ACC_IN[`PCR_LVL_HI:`PCR_LVL_LO];

   paging_ctrl_store #(
      .LEVELS (LEVELS)
   ) u_store (
      .clk        (MCLK),
      .rst_b      (RST_B),
      .wr_en      (go_wpcr),
      .wr_level   (acc_level),
      .wr_entry   (wr_entry),
      .rd_level_a (acc_level),
      .rd_level_b (CUR_LEVEL),
      .rd_entry_a (rd_entry),
      .rd_entry_b (cur_entry)
   );

   // read-back word with level and zero fields cleared
   wire [15:0] pcr_word = {5'h00, rd_entry.page_table_select,
                           rd_entry.alt_page_table_select, 5'h00,
                           rd_entry.ring};

   // ************************************************************
   // fault capture
   // ************************************************************
   wire fault_go   = FAULT_VALID && map_q;
   // a fault in the cycle of the read still lands: set beats clear
   wire fs_capture = fault_go && (!fs_locked_q || go_rfs);
   wire [15:0] fs_word;
   assign fs_word[`FS_FETCH_BIT]           = FAULT_INFO.is_fetch;
   assign fs_word[`FS_PERMIT_BIT]          = FAULT_INFO.permit;
   assign fs_word[13:8]                    = 6'h00;
   assign fs_word[`FS_PT_HI:`FS_PT_LO]     = FAULT_INFO.page_table_select;
   assign fs_word[`FS_VPN_HI:`FS_VPN_LO]   = FAULT_INFO.virtual_page_index;
   // page missing outranks protection in the code
   wire [3:0] fault_code = FAULT_INFO.page_miss ? `IIC_PAGE_FAULT
                                                : `IIC_PROTECT;

   // ************************************************************
   // interrupt selection: fault, then trap, then supervisor call
   // ************************************************************
   wire       irq_d      = fault_go || instr_trap || go_svc;
   wire [3:0] irq_code_d = fault_go   ? fault_code :
                           instr_trap ? `IIC_PRIV_INSTR : `IIC_SUPER_CALL;
   wire       acc_v_d    = go_rpcr || go_rfs;
   wire [15:0] acc_d     = go_rfs ? fs_q : pcr_word;

   // mode flags
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         map_q  <= 1'b0;
         wide_q <= 1'b0;
      end else begin
         if (go_pon) map_q <= 1'b1;
         else if (go_pof) map_q <= 1'b0;
         if (go_sex) wide_q <= 1'b1;
         else if (go_rex) wide_q <= 1'b0;
      end
   end

   // fault status and its lock
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         fs_q        <= 16'h0000;
         fs_locked_q <= 1'b0;
      end else begin
         if (fs_capture) fs_q <= fs_word;
         fs_locked_q <= fs_capture || (fs_locked_q && !go_rfs);
      end
   end

   // ************************************************************
   // registered outputs
   // ************************************************************
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         EXEC_DONE     <= 1'b0;
         EXEC_SUPPRESS <= 1'b0;
         IRQ_VALID     <= 1'b0;
         IRQ_LEVEL     <= 4'h0;
         IRQ_CODE      <= 4'h0;
         SVC_NUM       <= 8'h00;
         PC_HOLD       <= 1'b0;
      end else begin
         EXEC_DONE     <= instr_go;
         EXEC_SUPPRESS <= instr_trap;
         IRQ_VALID     <= irq_d;
         IRQ_LEVEL     <= irq_d ? `MMU_IRQ_LEVEL : IRQ_LEVEL;
         IRQ_CODE      <= irq_d ? irq_code_d : IRQ_CODE;
         SVC_NUM       <= go_svc ? INSTR_PARAM : SVC_NUM;
         PC_HOLD       <= fault_go && FAULT_INFO.is_fetch;
      end
   end

   // accumulator return and mode mirrors
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         ACC_VALID      <= 1'b0;
         ACC_OUT        <= 16'h0000;
         MAP_ON         <= 1'b0;
         PROTECT_ON     <= 1'b0;
         STS_WIDE       <= 1'b0;
         PHYS_ADDR_BITS <= `PADDR_NORMAL;
         CUR_PCR        <= '0;
      end else begin
         ACC_VALID      <= acc_v_d;
         ACC_OUT        <= acc_v_d ? acc_d : ACC_OUT;
         MAP_ON         <= map_q;
         PROTECT_ON     <= map_q;
         STS_WIDE       <= wide_q;
         PHYS_ADDR_BITS <= wide_q ? `PADDR_WIDE : `PADDR_NORMAL;
         CUR_PCR        <= cur_entry;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_B);

   // named behaviours, single-cycle and multi-step
   sequence s_trap;
      INSTR_VALID && op_priv && map_q && (EXEC_RING < `RING_PRIV_MIN) && !fault_go;
   endsequence
   sequence s_pon;
      go_pon && !go_pof;
   endsequence
   sequence s_mode_follows;
      ##1 !map_q ##1 !MAP_ON;
   endsequence
   sequence s_fs_read;
      go_rfs && !fault_go;
   endsequence
   sequence s_pcr_same;
      go_wpcr && (acc_level == CUR_LEVEL) ##1 (CUR_LEVEL == $past(CUR_LEVEL));
   endsequence
   sequence s_pcr_other;
      go_wpcr && (acc_level != CUR_LEVEL) ##1 (CUR_LEVEL == $past(CUR_LEVEL));
   endsequence

   // low ring privileged op is trapped
   AST_PRIV_TRAP: assert property (s_trap |=> EXEC_SUPPRESS && IRQ_VALID
      && (IRQ_CODE == `IIC_PRIV_INSTR) && !EXEC_DONE)
      else $error("privileged instruction on low ring not trapped");

   // high ring privileged op runs
   AST_PRIV_HIGH: assert property (INSTR_VALID && op_priv
      && (EXEC_RING >= `RING_PRIV_MIN) |=> EXEC_DONE && !EXEC_SUPPRESS)
      else $error("privileged instruction on high ring refused");

   // nothing refused while unmapped
   AST_UNMAPPED: assert property (INSTR_VALID && !map_q
      |=> !EXEC_SUPPRESS)
      else $error("instruction refused with mapping off");

   // mapping and protection follow paging on
   AST_PON: assert property (s_pon |=> ##1 (MAP_ON
      && PROTECT_ON))
      else $error("mapping not on after paging on");

   // mapping drops after paging off
   AST_POF: assert property (go_pof
      |-> s_mode_follows)
      else $error("mapping not off after paging off");

   // supervisor call raises its interrupt and number
   AST_SVC: assert property (go_svc && !fault_go |=> IRQ_VALID
      && (IRQ_CODE == `IIC_SUPER_CALL) && (SVC_NUM == $past(INSTR_PARAM)))
      else $error("supervisor call lost");

   // read-back word keeps level and zero bits clear
   AST_PCR_READ: assert property (go_rpcr && !go_rfs |=> ACC_VALID
      && (ACC_OUT[15:11] == 5'h00) && (ACC_OUT[6:2] == 5'h00))
      else $error("read-back word has stray bits");

   // ring written then read back at once
   AST_PCR_ROUND: assert property (go_wpcr ##1 (go_rpcr
      && (acc_level == $past(acc_level))) |=> ACC_OUT[1:0] == $past(ACC_IN[1:0], 2))
      else $error("ring field not kept");

   // status read returns the word and unlocks
   AST_FS_READ: assert property (s_fs_read |=> ACC_VALID
      && (ACC_OUT == $past(fs_q)) && !fs_locked_q)
      else $error("fault status read wrong or lock kept");

   // locked status is not overwritten
   AST_FS_HOLD: assert property (fs_locked_q && !go_rfs
      |=> $stable(fs_q))
      else $error("locked fault status changed");

   // capture sets fetch bit and lock
   AST_FS_BITS: assert property (fs_capture |=> (fs_q[`FS_FETCH_BIT] ==
      $past(FAULT_INFO.is_fetch)) && (fs_q[13:8] == 6'h00) && fs_locked_q)
      else $error("fault status capture wrong");

   // protection violation goes to its level and code
   AST_PROTECT_IRQ: assert property (fault_go && !FAULT_INFO.page_miss
      |=> IRQ_VALID && (IRQ_LEVEL == `MMU_IRQ_LEVEL) && (IRQ_CODE == `IIC_PROTECT))
      else $error("protection violation interrupt wrong");

   // counter held only for a fetch fault
   AST_FETCH_HOLD: assert property (fault_go
      |=> PC_HOLD == $past(FAULT_INFO.is_fetch))
      else $error("program counter hold wrong");

   // wide addressing follows set-wide
   AST_WIDE: assert property (go_sex && !go_rex |=> ##1 (STS_WIDE
      && (PHYS_ADDR_BITS == `PADDR_WIDE)))
      else $error("wide mode not set");

   // normal addressing follows reset-wide
   AST_NARROW: assert property (go_rex |=> ##1 (!STS_WIDE
      && (PHYS_ADDR_BITS == `PADDR_NORMAL)))
      else $error("normal mode not restored");

   // trapped op changes no mode and returns nothing
   AST_TRAP_INERT: assert property (instr_trap |=> $stable(map_q)
      && $stable(wide_q) && !ACC_VALID && !EXEC_DONE)
      else $error("trapped instruction took effect");

   // supervisor call is open to every ring
   AST_SVC_OPEN: assert property (INSTR_VALID
      && (INSTR_OP == mmu_ctrl_pkg::OP_SUPER_CALL) |=> EXEC_DONE && !EXEC_SUPPRESS)
      else $error("supervisor call refused");

   // low ring completes while unmapped
   AST_UNMAPPED_LOW: assert property (INSTR_VALID && !map_q
      && (EXEC_RING < `RING_PRIV_MIN) |=> EXEC_DONE)
      else $error("low ring instruction lost with mapping off");

   // running level sees its new control fields
   AST_PCR_WRITE: assert property (s_pcr_same
      |=> CUR_PCR == $past(wr_entry, 2))
      else $error("control fields not stored");

   // a write to another level leaves the running one alone
   AST_PCR_OTHER: assert property (s_pcr_other
      |=> $stable(CUR_PCR))
      else $error("write reached a second level");

   // permit bit captured
   AST_FS_PERMIT: assert property (fs_capture
      |=> fs_q[`FS_PERMIT_BIT] == $past(FAULT_INFO.permit))
      else $error("permit bit not captured");

   // table and page fields captured
   AST_FS_PLACE: assert property (fs_capture |=> (fs_q[`FS_PT_HI:`FS_PT_LO]
      == $past(FAULT_INFO.page_table_select)) && (fs_q[`FS_VPN_HI:`FS_VPN_LO]
      == $past(FAULT_INFO.virtual_page_index)))
      else $error("fault fields misplaced");

   // later fault still interrupts, lock stays
   AST_LOCK_KEEP: assert property (fault_go && fs_locked_q && !go_rfs
      |=> IRQ_VALID && fs_locked_q)
      else $error("fault under lock lost or unlocked");

   // page fault carries its own code
   AST_PAGE_IRQ: assert property (fault_go && FAULT_INFO.page_miss
      |=> IRQ_VALID && (IRQ_LEVEL == `MMU_IRQ_LEVEL) && (IRQ_CODE == `IIC_PAGE_FAULT))
      else $error("page fault interrupt wrong");

   // faults ignored while unmapped
   AST_FAULT_OFF: assert property (FAULT_VALID && !map_q && !INSTR_VALID
      |=> !IRQ_VALID && !PC_HOLD && $stable(fs_q))
      else $error("fault acted on with mapping off");

   // read result stands until the next read
   AST_ACC_HOLD: assert property (!go_rpcr && !go_rfs
      |=> !ACC_VALID && $stable(ACC_OUT))
      else $error("read result changed without a read");
endmodule : paging_control_and_privilege
`default_nettype wire

/* File: tb/cpu_exec_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// cpu-side model: instruction and fault issue
// ****************************************
module cpu_exec_model (
   input  wire logic                 clk,
   output logic                      instr_valid,
   output mmu_ctrl_pkg::instr_op_t   instr_op,
   output logic [7:0]                instr_param,
   output logic [15:0]               acc_in,
   output logic [1:0]                exec_ring,
   output logic                      fault_valid,
   output mmu_ctrl_pkg::fault_info_t fault_info,
   input  wire logic                 done,
   input  wire logic                 suppress,
   input  wire logic                 irq_valid,
   input  wire logic                 acc_valid,
   input  wire logic                 pc_hold
);
   // idle levels from time zero
   initial begin
      instr_valid = 1'h0;
      instr_op = mmu_ctrl_pkg::OP_PLAIN;
      instr_param = 8'h00;
      acc_in = 16'h0000;
      exec_ring = 2'h3;
      fault_valid = 1'h0;
      fault_info = '0;
   end

   // offer one instruction for one edge, gather {done,suppress,irq,accv}
   task automatic issue(input mmu_ctrl_pkg::instr_op_t op, input logic [1:0] ring,
                        input logic [15:0] acc, input logic [7:0] prm,
                        output logic [3:0] seen);
      int i;
      @(negedge clk);
      instr_valid = 1'h1;
      instr_op = op;
      exec_ring = ring;
      acc_in = acc; // level in bits 6:3 for reads
      instr_param = prm;
      seen = 4'h0;
      @(posedge clk);
      for (i = 0; i < 3; i++) begin
         @(negedge clk);
         instr_valid = 1'h0;
         acc_in = ~acc; // released operand stops holding its value
         instr_param = ~prm;
         seen = seen | {done, suppress, irq_valid, acc_valid};
      end
   endtask : issue

   // two instructions on successive edges, gather {done,suppress,irq,accv} of the second
   task automatic issue_pair(input mmu_ctrl_pkg::instr_op_t op_a, input logic [15:0] acc_a,
                             input mmu_ctrl_pkg::instr_op_t op_b, input logic [15:0] acc_b,
                             output logic [3:0] seen);
      @(negedge clk);
      instr_valid = 1'h1;
      instr_op = op_a;
      exec_ring = 2'h3;
      acc_in = acc_a;
      @(negedge clk);
      instr_op = op_b; // valid held high across both edges
      acc_in = acc_b;
      @(negedge clk);
      instr_valid = 1'h0;
      acc_in = ~acc_b;
      seen = {done, suppress, irq_valid, acc_valid};
      @(negedge clk);
   endtask : issue_pair

   // report one translation fault, gather {irq,pc_hold}
   task automatic report(input mmu_ctrl_pkg::fault_info_t fi, output logic [1:0] seen);
      int i;
      @(negedge clk);
      fault_valid = 1'h1;
      fault_info = fi; // permit set by reporter when both occur
      seen = 2'h0;
      @(posedge clk);
      for (i = 0; i < 3; i++) begin
         @(negedge clk);
         fault_valid = 1'h0;
         fault_info = ~fi;
         seen = seen | {irq_valid, pc_hold};
      end
   endtask : report
endmodule : cpu_exec_model
`default_nettype wire

/* File: tb/tb_paging_control_and_privilege.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
// ****************************************
// bench top
// ****************************************
module tb_paging_control_and_privilege;
   logic MCLK, RST_B, iv, fv, done, sup, irq, accv, map, prot, wide, hold;
   mmu_ctrl_pkg::instr_op_t   op;
   mmu_ctrl_pkg::fault_info_t fi;
   mmu_ctrl_pkg::pcr_entry_t  cur_pcr;
   logic [7:0]  prm, svc;
   logic [15:0] acc, acc_out;
   logic [1:0]  ring, f;
   logic [3:0]  cur_level, irq_level, irq_code, s;
   logic [4:0]  abits;
   int          mismatches, cmp_count;
   mmu_ctrl_pkg::instr_op_t privs [10] = '{mmu_ctrl_pkg::OP_IO, mmu_ctrl_pkg::OP_MM_INT,
      mmu_ctrl_pkg::OP_INTERLEVEL, mmu_ctrl_pkg::OP_PAGING_ON, mmu_ctrl_pkg::OP_PAGING_OFF,
      mmu_ctrl_pkg::OP_SET_WIDE, mmu_ctrl_pkg::OP_RESET_WIDE, mmu_ctrl_pkg::OP_WR_PCR,
      mmu_ctrl_pkg::OP_RD_PCR, mmu_ctrl_pkg::OP_RD_FAULT};

   paging_control_and_privilege uut (.MCLK(MCLK), .RST_B(RST_B), .INSTR_VALID(iv),
      .INSTR_OP(op), .INSTR_PARAM(prm), .ACC_IN(acc), .EXEC_RING(ring), .CUR_LEVEL(cur_level),
      .FAULT_VALID(fv), .FAULT_INFO(fi), .EXEC_DONE(done), .EXEC_SUPPRESS(sup),
      .IRQ_VALID(irq), .IRQ_LEVEL(irq_level), .IRQ_CODE(irq_code), .SVC_NUM(svc),
      .ACC_VALID(accv), .ACC_OUT(acc_out), .MAP_ON(map), .PROTECT_ON(prot), .STS_WIDE(wide),
      .PHYS_ADDR_BITS(abits), .PC_HOLD(hold), .CUR_PCR(cur_pcr));
   cpu_exec_model cpu (.clk(MCLK), .instr_valid(iv), .instr_op(op), .instr_param(prm),
      .acc_in(acc), .exec_ring(ring), .fault_valid(fv), .fault_info(fi), .done(done),
      .suppress(sup), .irq_valid(irq), .acc_valid(accv), .pc_hold(hold));

   // clock generation
   initial MCLK = 1'h0;
   always #12.5 MCLK = ~MCLK;

   // mapping off: the io, mm-int and interlevel classes run from ring 0
   task automatic t_free;
      for (int i = 0; i < 3; i++) begin
         cpu.issue(privs[i], 2'h0, 16'h0000, 8'h00, s);
         `CHK(s[3:2], 2'h2);
      end
   endtask : t_free

   // control words: stray bits dropped, one level written per instruction
   task automatic t_pcr;
      cpu.issue(mmu_ctrl_pkg::OP_WR_PCR, 2'h3, 16'hFEFE, 8'h00, s);
      cpu.issue(mmu_ctrl_pkg::OP_WR_PCR, 2'h3, 16'h0301, 8'h00, s);
      cpu.issue(mmu_ctrl_pkg::OP_RD_PCR, 2'h3, 16'h0078, 8'h00, s);
      `CHK(s[0], 1'h1);
      `CHK(acc_out, 16'h0682);
      cpu.issue(mmu_ctrl_pkg::OP_RD_PCR, 2'h3, 16'h0000, 8'h00, s);
      `CHK(acc_out, 16'h0301);
      cpu.issue(mmu_ctrl_pkg::OP_RD_PCR, 2'h3, 16'h0038, 8'h00, s);
      `CHK(acc_out, 16'h0000);
      cpu.issue_pair(mmu_ctrl_pkg::OP_WR_PCR, 16'h0219, mmu_ctrl_pkg::OP_RD_PCR, 16'h0018, s);
      `CHK({s, acc_out}, 20'h90201);
      cur_level = 4'hF;
      repeat (3) @(negedge MCLK);
      `CHK(cur_pcr, 6'h36);
   endtask : t_pcr

   // wide and normal physical addressing
   task automatic t_wide;
      cpu.issue(mmu_ctrl_pkg::OP_SET_WIDE, 2'h3, 16'h0000, 8'h00, s);
      `CHK({wide, abits}, 6'h38);
      cpu.issue(mmu_ctrl_pkg::OP_RESET_WIDE, 2'h3, 16'h0000, 8'h00, s);
      `CHK({wide, abits}, 6'h13);
      // control word rewritten after the mode change
      cpu.issue(mmu_ctrl_pkg::OP_WR_PCR, 2'h3, 16'h0682 | 16'h0078, 8'h00, s);
   endtask : t_wide

   // mapping on: low rings trapped without effect, high rings and calls allowed
   task automatic t_priv;
      cpu.issue(mmu_ctrl_pkg::OP_PAGING_ON, 2'h2, 16'h0000, 8'h00, s);
      `CHK({map, prot}, 2'h3);
      for (int r = 0; r < 2; r++) begin
         for (int i = 0; i < 10; i++) begin
            cpu.issue(privs[i], r[1:0], 16'h0078, 8'h00, s);
            `CHK({s[3:1], irq_level, irq_code}, 11'h3E4);
         end
      end
      `CHK({map, wide}, 2'h2);
      cpu.issue(mmu_ctrl_pkg::OP_RD_PCR, 2'h2, 16'h0078, 8'h00, s);
      `CHK({s, acc_out}, 20'h90682);
      cpu.issue(mmu_ctrl_pkg::OP_SUPER_CALL, 2'h0, 16'h0000, 8'hFF, s);
      `CHK({s[3:1], irq_code, svc}, 15'h51FF);
      cpu.issue(mmu_ctrl_pkg::OP_SUPER_CALL, 2'h0, 16'h0000, 8'h00, s);
      `CHK({irq_code, svc}, 12'h100);
   endtask : t_priv

   // faults: lock, protection and page-fault codes, fetch against data cycles
   task automatic t_fault;
      cpu.report(12'hEAA, f);
      `CHK({f, irq_level, irq_code}, 10'h3E2);
      cpu.report(12'h245, f);
      `CHK(f, 2'h2);
      cpu.report(12'h1FF, f);
      `CHK({f, irq_code}, 6'h23);
      cpu.issue(mmu_ctrl_pkg::OP_RD_FAULT, 2'h2, 16'h0000, 8'h00, s);
      `CHK(acc_out, 16'hC0AA);
      cpu.report(12'h245, f);
      cpu.issue(mmu_ctrl_pkg::OP_RD_FAULT, 2'h2, 16'h0000, 8'h00, s);
      `CHK(acc_out, 16'h0045);
   endtask : t_fault

   // mapping off again: faults ignored, nothing refused
   task automatic t_off;
      cpu.issue(mmu_ctrl_pkg::OP_PAGING_OFF, 2'h3, 16'h0000, 8'h00, s);
      `CHK({map, prot}, 2'h0);
      cpu.report(12'hEAA, f);
      `CHK(f, 2'h0);
      cpu.issue(mmu_ctrl_pkg::OP_WR_PCR, 2'h0, 16'h0000, 8'h00, s);
      `CHK(s[3:2], 2'h2);
   endtask : t_off

   // verdict and end of run
   task automatic results;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results

   // main sequence
   initial begin
      mismatches = 0;
      cmp_count = 0;
      cur_level = 4'h0;
      RST_B = 1'h0;
      repeat (3) @(negedge MCLK);
      RST_B = 1'h1;
      `CHK({map, wide, abits, accv}, 8'h26);
      t_free();
      t_pcr();
      t_wide();
      t_priv();
      t_fault();
      t_off();
      results();
   end

   // watchdog against a hang
   initial begin
      #100000;
      mismatches++;
      results();
   end
endmodule : tb_paging_control_and_privilege
`default_nettype wire
